/* src/dps_host.v */
`timescale 1ns/1ps
`default_nettype none
`include "dps_defines.vh"
// ----------------------------------------------------------------
// host controller driving one port of the two-port memory
// ----------------------------------------------------------------
module dps_host
#(
   parameter AW = 15,
   parameter DW = 16
)
(
   // clock and reset
   input  wire          clk,
   input  wire          rstn,
   // apb slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [11:0]   paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   // memory port pins
   output reg           port_select_low,
   output reg           port_select_high,
   output reg           rw_n,
   output reg           out_en_n,
   output reg           high_lane_select_n,
   output reg           low_lane_select_n,
   output reg           flag_select_n,
   output reg  [AW-1:0] addr,
   input  wire [DW-1:0] data_i,
   output reg  [DW-1:0] data_o,
   output reg           data_oe,
   // flags from the device
   input  wire          busy_n,
   input  wire          int_n
);
   localparam [2:0] S_IDLE  = 3'd0;
   localparam [2:0] S_SETUP = 3'd1;
   localparam [2:0] S_STRB  = 3'd2;
   localparam [2:0] S_REL   = 3'd3;
   localparam [2:0] S_GAP   = 3'd4;
   // strobe count is worked out as an integer and cut to the counter width
   localparam integer ACC_CYC_I = `DPS_ACCESS_CYC;
   localparam [3:0]   ACC_CYC   = ACC_CYC_I[3:0];

   reg  [1:0]    rst_sync_r;
   wire          rst_n = rst_sync_r[1];
   reg  [5:0]    ctrl_r;
   // fifteen address bits reach all 32K words of 16 bits
   reg  [AW-1:0] addr_r;
   reg  [DW-1:0] wdata_r;
   reg  [DW-1:0] rdata_r;
   reg  [2:0]    state_r;
   reg  [3:0]    cnt_r;
   reg           done_r;
   reg           go_r;
   reg  [2:0]    state_nxt;
   reg  [3:0]    cnt_nxt;
   reg  [DW-1:0] din_r;
   wire [1:0]    pins_s;
   wire          busy_s = ~pins_s[0];
   wire          int_s  = ~pins_s[1];
   wire          active = (state_r != S_IDLE);
   wire          wr_en  = psel & penable & pwrite;
   wire          is_flag = ctrl_r[`DPS_CTRL_FLAG];
   wire          hold_busy = ctrl_r[`DPS_CTRL_WAITB] & busy_s;

   // ----------------------------------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------------------------------
   // reset arrives asynchronously but leaves on the clock
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rst_sync_r <= 2'b00;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end

   // busy and interrupt are asynchronous device outputs, always driven,
   // so no pull is needed; busy comes from the chain master's output
   dps_sync2 #(.W(2)) u_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({int_n, busy_n}),
      .q     (pins_s)
   );

   // ----------------------------------------------------------------
   // apb register file
   // ----------------------------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // read mux; unmapped offsets read zero
   always @*
   begin
      case (paddr)
         `DPS_REG_CTRL:   prdata = {26'h0, ctrl_r};
         `DPS_REG_ADDR:   prdata = {{(32-AW){1'b0}}, addr_r};
         `DPS_REG_WDATA:  prdata = {{(32-DW){1'b0}}, wdata_r};
         `DPS_REG_RDATA:  prdata = {{(32-DW){1'b0}}, rdata_r};
         `DPS_REG_STATUS: prdata = {28'h0, int_s, busy_s, done_r, active};
         default:         prdata = 32'h0;
      endcase
   end

   // register writes; a go while active is ignored
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r  <= `DPS_CTRL_RST;
         addr_r  <= {AW{1'b0}};
         wdata_r <= {DW{1'b0}};
         go_r    <= 1'b0;
      end
      else
      begin
         go_r <= 1'b0;
         if (wr_en && paddr == `DPS_REG_CTRL && !active)
         begin
            ctrl_r <= pwdata[5:0];
            go_r   <= pwdata[`DPS_CTRL_GO];
         end
         if (wr_en && paddr == `DPS_REG_ADDR && !active)
            addr_r <= pwdata[AW-1:0];
         if (wr_en && paddr == `DPS_REG_WDATA && !active)
            wdata_r <= pwdata[DW-1:0];
      end
   end

   // ----------------------------------------------------------------
   // read data capture
   // ----------------------------------------------------------------
   // the data pins are asynchronous too; this flop plus rdata_r makes two,
   // and the strobe is held long enough that the word is settled here
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         din_r <= {DW{1'b0}};
      else
         din_r <= data_i;
   end

   // ----------------------------------------------------------------
   // sequencer state and strobe counter
   // ----------------------------------------------------------------
   // next state; the pin actions below key off the same conditions
   always @*
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         S_IDLE:
         begin
            if (go_r)
               state_nxt = S_SETUP;
         end
         S_SETUP:
         begin
            if (!hold_busy)
            begin
               cnt_nxt   = ACC_CYC;     // strobe stands ACC_CYC + 1 cycles
               state_nxt = S_STRB;
            end
         end
         S_STRB:
         begin
            if (cnt_r != 4'h0)
               cnt_nxt = cnt_r - 4'h1;
            else
               state_nxt = S_REL;
         end
         S_REL:
            state_nxt = S_GAP;
         S_GAP:
            state_nxt = S_IDLE;
         default:
            state_nxt = S_IDLE;
      endcase
   end

   // state register, kept apart from the pin block so that
   // one process owns each register
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= S_IDLE;
         cnt_r   <= 4'h0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // port sequencer
   // ----------------------------------------------------------------
   // setup drives address and selects, strobe holds for access time,
   // release raises the strobe so a flag write lands on the rising edge
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_r             <= 1'b0;
         rdata_r            <= {DW{1'b0}};
         port_select_low    <= 1'b1;  // deselected, standby
         port_select_high   <= 1'b0;
         rw_n               <= 1'b1;
         out_en_n           <= 1'b1;
         high_lane_select_n <= 1'b1;
         low_lane_select_n  <= 1'b1;
         flag_select_n      <= 1'b1;
         addr               <= {AW{1'b0}};
         data_o             <= {DW{1'b0}};
         data_oe            <= 1'b0;
      end
      else
      begin
         case (state_r)
            S_IDLE:
            begin
               if (go_r)
               begin
                  done_r <= 1'b0;
                  addr   <= addr_r;
                  if (is_flag)
                  begin
                     // memory idle and both lanes off for flag access
                     port_select_low    <= 1'b1;
                     port_select_high   <= 1'b0;
                     high_lane_select_n <= 1'b1;
                     low_lane_select_n  <= 1'b1;
                     flag_select_n      <= 1'b0;
                     data_o <= {{(DW-1){1'b0}}, wdata_r[0]};
                  end
                  else
                  begin
                     port_select_low    <= 1'b0;
                     port_select_high   <= 1'b1;
                     high_lane_select_n <= ~ctrl_r[`DPS_CTRL_HLANE];
                     low_lane_select_n  <= ~ctrl_r[`DPS_CTRL_LLANE];
                     flag_select_n      <= 1'b1;
                     data_o             <= wdata_r;
                  end
               end
            end
            S_SETUP:
            begin
               // wait out busy if asked, so the device holds no write
               // without the wait, same-address access is left to the cells
               if (!hold_busy)
               begin
                  if (ctrl_r[`DPS_CTRL_WRITE])
                  begin
                     rw_n    <= 1'b0;
                     data_oe <= 1'b1;
                  end
                  else
                     out_en_n <= 1'b0;
               end
            end
            S_STRB:
            begin
               // counter runs out: take the settled word and raise the strobes
               if (cnt_r == 4'h0)
               begin
                  if (!ctrl_r[`DPS_CTRL_WRITE])
                     rdata_r <= din_r;   // flag reads show value on all bits
                  rw_n     <= 1'b1;      // rising strobe commits flag write
                  out_en_n <= 1'b1;
               end
            end
            S_REL:
            begin
               // data held one cycle past the strobe edge for hold time
               data_oe            <= 1'b0;
               port_select_low    <= 1'b1;
               port_select_high   <= 1'b0;
               high_lane_select_n <= 1'b1;
               low_lane_select_n  <= 1'b1;
               flag_select_n      <= 1'b1;
            end
            S_GAP:
            begin
               done_r  <= 1'b1;
            end
            default:
               data_oe <= 1'b0;   // stray code: let go of the data bus
         endcase
      end
   end
endmodule // dps_host
`default_nettype wire

/* src/dps_defines.vh */
// Behaviour
// - plain read/write only relied on when port addresses differ.
// - never assert flag select with port enabled and a lane select low.
// - devices cascade for wider words; master makes busy, slaves take it.
// - opposite enables allow depth expansion by upper address decode.
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH
// ----------------------------------------------------------------
// register offsets of the controller
// ----------------------------------------------------------------
`define DPS_REG_CTRL    12'h000
`define DPS_REG_ADDR    12'h004
`define DPS_REG_WDATA   12'h008
`define DPS_REG_RDATA   12'h00C
`define DPS_REG_STATUS  12'h010
// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define DPS_CTRL_GO     0
`define DPS_CTRL_WRITE  1
`define DPS_CTRL_FLAG   2
`define DPS_CTRL_HLANE  3
`define DPS_CTRL_LLANE  4
`define DPS_CTRL_WAITB  5
// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define DPS_ST_BUSY     0
`define DPS_ST_DONE     1
`define DPS_ST_BUSYPIN  2
`define DPS_ST_INTPIN   3
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define DPS_CTRL_RST    6'h18
`define DPS_ACCESS_NS   15
`define DPS_CLK_NS      8
`define DPS_ACCESS_CYC  ((`DPS_ACCESS_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`endif

/* src/dps_sync2.v */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// two-flop synchroniser, one per bit
// ----------------------------------------------------------------
module dps_sync2
#(
   parameter W = 1
)
(
   // clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // level in and out
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // first flop feeds only the second; resets to ones, the idle level of
   // the active-low flags, so no false assertion shows right after reset
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= {W{1'b1}};
         sync_r <= {W{1'b1}};
      end
      else
      begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end
   assign q = sync_r;
endmodule // dps_sync2
`default_nettype wire

/* bench/dps_host_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------
// port pin checks
// --------------------
module dps_host_asserts
#(
   parameter AW = 15,
   parameter DW = 16
)
(
   // clock, reset, apb answer
   input wire logic          clk,
   input wire logic          rstn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pready,
   input wire logic          pslverr,
   // memory port pins
   input wire logic          port_select_low,
   input wire logic          port_select_high,
   input wire logic          rw_n,
   input wire logic          out_en_n,
   input wire logic          high_lane_select_n,
   input wire logic          low_lane_select_n,
   input wire logic          flag_select_n,
   input wire logic [AW-1:0] addr,
   input wire logic          data_oe
);
   // selected needs both enables; lane means a byte lane is on
   wire sel = !port_select_low && port_select_high;
   wire lane = !high_lane_select_n || !low_lane_select_n;
   wire strb = !rw_n || !out_en_n;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   apb_answer_a: assert property (psel && penable |-> pready && !pslverr)
      else $error("apb access not answered");
   flag_forbid_a: assert property (!flag_select_n |-> !(sel && lane))
      else $error("flag select with lane enabled");
   strobe_excl_a: assert property (!(!rw_n && !out_en_n))
      else $error("both strobes low");
   wr_len_a: assert property ($fell(rw_n) |-> (!rw_n) [*3] ##1 rw_n)
      else $error("write strobe length wrong");
   rd_len_a: assert property ($fell(out_en_n) |-> (!out_en_n) [*3] ##1 out_en_n)
      else $error("read strobe length wrong");
   pins_hold_a: assert property (strb |-> $stable(addr) && $stable(flag_select_n))
      else $error("address moved under strobe");
   strobe_sel_a: assert property (strb |-> sel || !flag_select_n)
      else $error("strobe with nothing selected");
   wr_drive_a: assert property (!rw_n |-> data_oe)
      else $error("write without driving data");
   rd_float_a: assert property (!out_en_n |-> !data_oe)
      else $error("host drives bus during read");
   cover property ($fell(rw_n) && flag_select_n);
   cover property ($fell(rw_n) && !flag_select_n);
   cover property ($fell(out_en_n) && !flag_select_n);
endmodule // dps_host_asserts
`default_nettype wire

/* bench/dps_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------
// two-port memory, one port modelled
// --------------------
module dps_mem_model
(
   // clock only paces the float pattern
   input wire logic        clk,
   // port pins
   input wire logic        port_select_low,
   input wire logic        port_select_high,
   input wire logic        rw_n,
   input wire logic        out_en_n,
   input wire logic        high_lane_select_n,
   input wire logic        low_lane_select_n,
   input wire logic        flag_select_n,
   input wire logic [14:0] addr,
   input wire logic [15:0] data_o,
   input wire logic        data_oe,
   // flag requests from the bench
   input wire logic        busy_req,
   input wire logic        int_req,
   // answers
   output logic [15:0]     data_i,
   output logic            busy_n,
   output logic            int_n
);
   // only this port is modelled, so its addresses never collide
   logic [15:0] mem [0:32767];
   logic [7:0]  flag = 8'hFF;
   logic [15:0] last = 16'h0000;
   wire sel = !port_select_low && port_select_high;
   wire off = high_lane_select_n && low_lane_select_n;
   wire mrd = sel && rw_n && !out_en_n && flag_select_n;
   wire frd = !flag_select_n && rw_n && !out_en_n && (!sel || off);
   wire [15:0] rv = frd ? {16{flag[addr[2:0]]}} : mem[addr];
   wire [15:0] en = frd ? 16'hFFFF : mrd ? {{8{!high_lane_select_n}}, {8{!low_lane_select_n}}}
                   : 16'h0000;
   // floating lanes show the inverse of the last bus value, not a held copy
   assign data_i = (rv & en) | (~last & ~en);
   // master role: flags pushed out, never floated
   assign busy_n = !busy_req;
   assign int_n = !int_req;
   always @(posedge clk) last <= data_oe ? data_o : data_i;
   // writes land at the strobe end; a busy port loses its memory write
   always @(posedge rw_n)
   begin
      if (sel && flag_select_n && !busy_req)
      begin
         if (!high_lane_select_n) mem[addr][15:8] <= data_o[15:8];
         if (!low_lane_select_n) mem[addr][7:0] <= data_o[7:0];
      end
      else if (!flag_select_n && (!sel || off))
         flag[addr[2:0]] <= data_o[0];
   end
endmodule // dps_mem_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------
// host controller bench
// --------------------
module testbench;
   logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, busy_req = 0, int_req = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, pl, ph, rw_n, oe_n, hl, ll, fs, doe, busy_n, int_n;
   wire  [14:0] addr;
   wire  [15:0] di, dq;
   int          fails = 0, compares = 0, cyc = 0;
   always #4 clk = ~clk;
   dps_host u_dps_host (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .port_select_low(pl), .port_select_high(ph), .rw_n, .out_en_n(oe_n),
      .high_lane_select_n(hl), .low_lane_select_n(ll), .flag_select_n(fs), .addr,
      .data_i(di), .data_o(dq), .data_oe(doe), .busy_n, .int_n);
   dps_mem_model u_dps_mem_model (.clk, .port_select_low(pl), .port_select_high(ph), .rw_n,
      .out_en_n(oe_n), .high_lane_select_n(hl), .low_lane_select_n(ll), .flag_select_n(fs),
      .addr, .data_o(dq), .data_oe(doe), .busy_req, .int_req, .data_i(di), .busy_n, .int_n);
   task test_done;
      $display("checks %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      psel <= 0; penable <= 0;
   endtask
   task start(input logic [7:0] c, input logic [14:0] a, input logic [15:0] d);
      apb(1, 12'h004, {17'h0, a});
      apb(1, 12'h008, {16'h0, d});
      apb(1, 12'h000, {24'h0, c});
   endtask
   // poll status until done, a bounded number of times
   task wait_done;
      int n;
      n = 0; rd = 32'h0;
      while (rd[1] !== 1'b1 && n < 60)
      begin
         apb(0, 12'h010, 32'h0); n++;
      end
      chk({31'h0, rd[1]}, 32'h1);
   endtask
   // run one access, then fetch the read word
   task acc(input logic [7:0] c, input logic [14:0] a, input logic [15:0] d);
      start(c, a, d);
      wait_done;
      apb(0, 12'h00C, 32'h0);
      rd = {16'h0, rd[15:0]};
   endtask
   task t_reset;
      apb(0, 12'h000, 32'h0); chk(rd, 32'h18);
      apb(0, 12'h010, 32'h0); chk(rd, 32'h0);
      apb(1, 12'h020, 32'hFFFFFFFF); apb(0, 12'h020, 32'h0); chk(rd, 32'h0);
      $display("reset test over");
   endtask
   task t_word;
      logic [14:0] a [3];
      a = '{15'h0000, 15'h7FFF, 15'h2AAA};
      foreach (a[i]) acc(8'h1B, a[i], {1'b0, a[i]} ^ 16'hA5C3);
      foreach (a[i])
      begin
         acc(8'h19, a[i], 16'h0); chk(rd, {17'h0, a[i]} ^ 32'hA5C3);
      end
      $display("word test over");
   endtask
   task t_lane;
      acc(8'h1B, 15'h5, 16'h1234); acc(8'h0B, 15'h5, 16'hABCD); acc(8'h03, 15'h5, 16'h0);
      acc(8'h19, 15'h5, 16'h0); chk(rd, 32'hAB34);
      acc(8'h11, 15'h5, 16'h0); chk(rd & 32'hFF, 32'h34);
      $display("lane test over");
   endtask
   task t_flag;
      acc(8'h07, 15'h000B, 16'hFFFE); acc(8'h05, 15'h3, 16'h0); chk(rd, 32'h0);
      acc(8'h05, 15'h4, 16'h0); chk(rd, 32'hFFFF);
      acc(8'h07, 15'h3, 16'h1); acc(8'h05, 15'h3, 16'h0); chk(rd, 32'hFFFF);
      $display("flag test over");
   endtask
   task t_busy;
      busy_req <= 1; int_req <= 1;
      start(8'h3B, 15'h9, 16'h5A5A);
      repeat (20) @(posedge clk);
      apb(0, 12'h010, 32'h0); chk(rd & 32'hF, 32'hD);
      busy_req <= 0; int_req <= 0;
      wait_done;
      acc(8'h19, 15'h9, 16'h0); chk(rd, 32'h5A5A);
      acc(8'h19, 15'h9, 16'h0); chk(rd, 32'h5A5A);
      $display("busy test over");
   endtask
   // cut a hang short
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails = fails + 1;
         test_done;
      end
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rstn <= 1;
      repeat (3) @(posedge clk);
      t_reset; t_word; t_lane; t_flag; t_busy;
      test_done;
   end
endmodule // testbench
bind dps_host dps_host_asserts #(.AW(AW), .DW(DW)) u_dps_host_asserts (.clk, .rstn, .psel,
   .penable, .pready, .pslverr, .port_select_low, .port_select_high, .rw_n, .out_en_n,
   .high_lane_select_n, .low_lane_select_n, .flag_select_n, .addr, .data_oe);
`default_nettype wire
